// File: core/spt_compress.v
// Linear to 8-bit mu-law or A-law compressor, combinational
`timescale 1ns/100ps
`default_nettype none
module spt_compress (
  input wire [15:0] din,
  input wire alaw,
  output reg [7:0] code
);
  reg sign;
  reg [15:0] x;
  reg [12:0] m;
  reg [2:0] seg;
  reg [3:0] mant;
  integer i;
  // Magnitude, clamp, segment search; out-of-range input saturates
  always @* begin
    sign = din[15];
    x = sign ? (16'h0000 - din) : din;
    seg = 3'h0;
    mant = 4'h0;
    m = 13'h0000;
    if (alaw) begin
      m = (x[15:3] > 13'h0FFF) ? 13'h0FFF : x[15:3];
      for (i = 1; i < 8; i = i + 1) begin
        if (m >= (13'h0010 << i)) seg = i[2:0];
      end
      mant = (seg == 3'h0) ? m[4:1] : m[seg +: 4];
      code = {~sign, seg, mant} ^ 8'h55;
    end else begin
      m = (x[15:2] > 14'h1FDE) ? 13'h1FDE : x[14:2];
      m = m + 13'h0021;
      for (i = 1; i < 8; i = i + 1) begin
        if (m >= (13'h0020 << i)) seg = i[2:0];
      end
      mant = m[({1'b0, seg} + 4'h1) +: 4]; // Widened so segment 7 does not wrap to 0
      code = ~{sign, seg, mant};
    end
  end
endmodule
`default_nettype wire

// File: core/spt_consts.vh
// Register map, field positions and reset values of the serial transmit framer
`ifndef SPT_CONSTS_VH
`define SPT_CONSTS_VH
`define SPT_OFS_PCTL1 8'h00
`define SPT_OFS_PCTL2 8'h04
`define SPT_OFS_TCTL1 8'h08
`define SPT_OFS_TCTL2 8'h0C
`define SPT_OFS_MCTL2 8'h10
`define SPT_OFS_CHEN 8'h14
`define SPT_OFS_TXDATA 8'h18
`define SPT_OFS_RXBUF 8'h1C
`define SPT_OFS_RXDATA 8'h20
`define SPT_OFS_CMPRES 8'h24
`define SPT_BIT_RX_EN 0
`define SPT_BIT_BITLVL 6
`define SPT_BIT_TX_EN 0
`define SPT_BIT_SYNCERR 1
`define SPT_BIT_TXRDY 2
`define SPT_BIT_PHASE 15
`define SPT_BIT_IGNORE 2
`define SPT_FLD_FRLEN 14:8
`define SPT_FLD_WDLEN 7:5
`define SPT_FLD_CMP 4:3
`define SPT_FLD_CHM 1:0
`define SPT_RST_WORD 32'h00000000
`define SPT_CMP_NONE 2'h0
`define SPT_CMP_LSB 2'h1
`define SPT_CMP_MU 2'h2
`define SPT_CMP_A 2'h3
`define SPT_CHM_ALL 2'h0
`define SPT_CHM_MASK 2'h2
`define SPT_RESP_OK 2'h0
`define SPT_RESP_ERR 2'h2
`endif

// File: core/spt_expand.v
// 8-bit mu-law or A-law code to 16-bit two's complement expander
`timescale 1ns/100ps
`default_nettype none
module spt_expand (
  input wire [7:0] code,
  input wire alaw,
  output reg [15:0] dout
);
  reg [7:0] c;
  reg [15:0] t;
  // Segment and mantissa rebuild the linear magnitude
  always @* begin
    c = alaw ? (code ^ 8'h55) : ~code;
    if (alaw) begin
      t = {8'h00, c[3:0], 4'h8};
      if (c[6:4] != 3'h0) t = (t + 16'h0100) << (c[6:4] - 3'h1);
      dout = c[7] ? t : (16'h0000 - t);
    end else begin
      t = ({9'h000, c[3:0], 3'h0} + 16'h0084) << c[6:4];
      dout = c[7] ? (16'h0084 - t) : (t - 16'h0084);
    end
  end
endmodule
`default_nettype wire

// File: core/spt_tx.v
// Serial port transmit framer with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none
`include "spt_consts.vh"
module spt_tx (
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire tx_bclk,
  input wire tx_fsync,
  output reg tx_dout,
  output reg tx_dout_oe
);
  localparam ST_IDLE = 2'b01;
  localparam ST_SHIFT = 2'b10;

  // Word length in bits for a 3-bit code; reserved codes fall back to 8
  function [5:0] wlen;
    input [2:0] c;
    begin
      case (c)
        3'h0: wlen = 6'd8;
        3'h1: wlen = 6'd12;
        3'h2: wlen = 6'd16;
        3'h3: wlen = 6'd20;
        3'h4: wlen = 6'd24;
        3'h5: wlen = 6'd32;
        default: wlen = 6'd8;
      endcase
    end
  endfunction

  // Byte-lane merge of a write into a stored word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[8*k +: 8] = strb[k] ? nw[8*k +: 8] : old[8*k +: 8];
      end
    end
  endfunction

  reg [31:0] pctl1_q, pctl2_q, tctl1_q, tctl2_q, mctl2_q, chen_q;
  reg [31:0] txdata_q, cur_word_q, rxdata_q, cmpres_q;
  reg tx_full_q, syncerr_q;
  reg aw_held_q, w_held_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bclk_s1_q, bclk_s2_q, bclk_s3_q, fs_s1_q, fs_s2_q;
  reg [1:0] state_q;
  reg phase_q;
  reg [6:0] word_q;
  reg [7:0] slot_q;
  reg [5:0] left_q;
  reg [4:0] bidx_q;
  reg [31:0] shift_q;
  reg wdrive_q;

  wire tx_en = pctl2_q[`SPT_BIT_TX_EN];
  wire rx_en = pctl1_q[`SPT_BIT_RX_EN];
  wire bit_level = pctl1_q[`SPT_BIT_BITLVL];
  wire dual = tctl2_q[`SPT_BIT_PHASE];
  wire ignore = tctl2_q[`SPT_BIT_IGNORE];
  wire [1:0] cmp_sel = tctl2_q[`SPT_FLD_CMP];
  wire [1:0] ch_mode = mctl2_q[`SPT_FLD_CHM];
  wire [1:0] rx_cmp = pctl1_q[`SPT_FLD_CMP];
  wire wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire rise = bclk_s2_q & ~bclk_s3_q;
  // Write address decode
  wire wr_data = wr_go & (awaddr_q == `SPT_OFS_TXDATA);
  wire wr_rxbuf = wr_go & (awaddr_q == `SPT_OFS_RXBUF);
  wire wr_map = wr_go & ((awaddr_q <= `SPT_OFS_RXBUF) & (awaddr_q[1:0] == 2'h0));

  // Compander instances; the compressor reads the data register path, the expander the receive buffer
  wire [31:0] rxbuf_w = merge(32'h00000000, wdata_q, wstrb_q);
  wire [31:0] data_w = merge(txdata_q, wdata_q, wstrb_q);
  wire [31:0] src_w = tx_full_q ? txdata_q : cur_word_q;
  wire [7:0] cmp_code;
  wire [15:0] exp_lin;
  spt_compress spt_compress_inst (
    .din(tx_en ? src_w[15:0] : data_w[15:0]),
    .alaw(tx_en ? (cmp_sel == `SPT_CMP_A) : (rx_cmp == `SPT_CMP_A)),
    .code(cmp_code)
  );
  spt_expand spt_expand_inst (
    .code(rxbuf_w[7:0]),
    .alaw(rx_cmp == `SPT_CMP_A),
    .dout(exp_lin)
  );

  // Link inputs through two flops; the third flop only feeds edge detection
  always @(posedge clk) begin
    if (rst) begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
    end else begin
      bclk_s1_q <= tx_bclk;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
      fs_s1_q <= tx_fsync;
      fs_s2_q <= fs_s1_q;
    end
  end

  // Frame sequencing terms for the current bit-clock edge
  reg [6:0] frlen_c;
  reg eof_c, unexp_c, restart_c, adv_c, nphase_c, sel_c, en_c, drive_c;
  reg [6:0] nword_c;
  reg [7:0] nslot_c;
  reg [5:0] nlen_c;
  reg [31:0] nshift_c;
  always @* begin
    frlen_c = phase_q ? tctl2_q[`SPT_FLD_FRLEN] : tctl1_q[`SPT_FLD_FRLEN];
    eof_c = (state_q == ST_SHIFT) & (left_q == 6'd1) & (word_q == frlen_c)
      & (phase_q | ~dual);
    unexp_c = rise & tx_en & (state_q == ST_SHIFT) & fs_s2_q & ~eof_c;
    restart_c = rise & tx_en & fs_s2_q & ((state_q == ST_IDLE) | eof_c | ~ignore);
    adv_c = rise & tx_en & ~restart_c & (state_q == ST_SHIFT) & (left_q == 6'd1) & ~eof_c;
    nphase_c = 1'b0;
    nword_c = 7'h00;
    nslot_c = 8'h00;
    if (adv_c) begin
      nphase_c = (word_q == frlen_c) ? 1'b1 : phase_q;
      nword_c = (word_q == frlen_c) ? 7'h00 : word_q + 7'h01;
      nslot_c = slot_q + 8'h01;
    end
    // Companded and LSB-first words are always 8 bits
    nlen_c = (cmp_sel != `SPT_CMP_NONE) ? 6'd8 :
      wlen(nphase_c ? tctl2_q[`SPT_FLD_WDLEN] : tctl1_q[`SPT_FLD_WDLEN]);
    case (cmp_sel)
      `SPT_CMP_NONE: nshift_c = src_w << (6'd32 - nlen_c);
      `SPT_CMP_LSB: nshift_c = {src_w[0], src_w[1], src_w[2], src_w[3],
        src_w[4], src_w[5], src_w[6], src_w[7], 24'h000000};
      default: nshift_c = {cmp_code, 24'h000000};
    endcase
    // Channels above 31 have no enable bit and count as unselected
    sel_c = (nslot_c < 8'd32) & chen_q[nslot_c[4:0]];
    case (ch_mode)
      `SPT_CHM_ALL: begin
        en_c = 1'b1;
        drive_c = 1'b1;
      end
      `SPT_CHM_MASK: begin
        en_c = 1'b1;
        drive_c = sel_c;
      end
      default: begin
        en_c = sel_c;
        drive_c = sel_c;
      end
    endcase
  end
  // Transmit state machine
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      phase_q <= 1'b0;
      word_q <= 7'h00;
      slot_q <= 8'h00;
      left_q <= 6'd0;
      bidx_q <= 5'h00;
      shift_q <= `SPT_RST_WORD;
      wdrive_q <= 1'b0;
      tx_dout <= 1'b0;
      tx_dout_oe <= 1'b0;
    end else if (!tx_en) begin
      state_q <= ST_IDLE;
      tx_dout <= 1'b0;
      tx_dout_oe <= 1'b0;
    end else if (restart_c | adv_c) begin
      state_q <= ST_SHIFT;
      phase_q <= nphase_c;
      word_q <= nword_c;
      slot_q <= nslot_c;
      left_q <= nlen_c;
      bidx_q <= 5'h00;
      shift_q <= nshift_c;
      wdrive_q <= drive_c;
      tx_dout <= nshift_c[31];
      tx_dout_oe <= bit_level ? chen_q[0] : drive_c;
    end else if (rise) begin
      case (state_q)
        ST_IDLE: tx_dout_oe <= 1'b0;
        ST_SHIFT: begin
          if (left_q == 6'd1) begin
            state_q <= ST_IDLE;
            tx_dout_oe <= 1'b0;
          end else begin
            left_q <= left_q - 6'd1;
            bidx_q <= bidx_q + 5'h01;
            shift_q <= {shift_q[30:0], 1'b0};
            tx_dout <= shift_q[30];
            tx_dout_oe <= bit_level ? chen_q[bidx_q + 5'h01] : wdrive_q;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Software registers; hardware set of flags wins over a same-cycle clear
  always @(posedge clk) begin
    if (rst) begin
      pctl1_q <= `SPT_RST_WORD;
      pctl2_q <= `SPT_RST_WORD;
      tctl1_q <= `SPT_RST_WORD;
      tctl2_q <= `SPT_RST_WORD;
      mctl2_q <= `SPT_RST_WORD;
      chen_q <= `SPT_RST_WORD;
      txdata_q <= `SPT_RST_WORD;
      cur_word_q <= `SPT_RST_WORD;
      rxdata_q <= `SPT_RST_WORD;
      cmpres_q <= `SPT_RST_WORD;
      tx_full_q <= 1'b0;
      syncerr_q <= 1'b0;
    end else begin
      if (wr_go) begin
        case (awaddr_q)
          `SPT_OFS_PCTL1: pctl1_q <= merge(pctl1_q, wdata_q, wstrb_q);
          `SPT_OFS_PCTL2: pctl2_q <= merge(pctl2_q, wdata_q, wstrb_q) & 32'h00000001;
          `SPT_OFS_TCTL1: tctl1_q <= merge(tctl1_q, wdata_q, wstrb_q);
          `SPT_OFS_TCTL2: tctl2_q <= merge(tctl2_q, wdata_q, wstrb_q);
          `SPT_OFS_MCTL2: mctl2_q <= merge(mctl2_q, wdata_q, wstrb_q);
          `SPT_OFS_CHEN: chen_q <= merge(chen_q, wdata_q, wstrb_q);
          default: ;
        endcase
      end
      // A load takes the data register once per enabled word
      if ((restart_c | adv_c) & en_c & tx_full_q) begin
        cur_word_q <= txdata_q;
        tx_full_q <= 1'b0;
      end
      if (wr_data) begin
        txdata_q <= data_w;
        tx_full_q <= 1'b1;
        if (!tx_en && !rx_en) cmpres_q <= {24'h000000, cmp_code};
      end
      // Receive buffer copy, expanded when receive companding is on
      if (wr_rxbuf) begin
        rxdata_q <= rx_cmp[1] ? {{16{exp_lin[15]}}, exp_lin} : rxbuf_w;
      end
      if (wr_go & (awaddr_q == `SPT_OFS_PCTL2) & wstrb_q[0] & wdata_q[`SPT_BIT_SYNCERR])
        syncerr_q <= 1'b0;
      if (unexp_c & ~ignore) syncerr_q <= 1'b1;
    end
  end

  // AXI4-Lite write channel: address and data taken in either order
  always @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPT_RESP_OK;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `SPT_RESP_OK : `SPT_RESP_ERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel; reads have no side effects
  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SPT_RESP_OK;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SPT_RESP_OK;
      case (s_axi_araddr)
        `SPT_OFS_PCTL1: s_axi_rdata <= pctl1_q;
        `SPT_OFS_PCTL2: s_axi_rdata <= {29'h0, ~tx_full_q, syncerr_q, pctl2_q[0]};
        `SPT_OFS_TCTL1: s_axi_rdata <= tctl1_q;
        `SPT_OFS_TCTL2: s_axi_rdata <= tctl2_q;
        `SPT_OFS_MCTL2: s_axi_rdata <= mctl2_q;
        `SPT_OFS_CHEN: s_axi_rdata <= chen_q;
        `SPT_OFS_TXDATA: s_axi_rdata <= txdata_q;
        `SPT_OFS_RXBUF: s_axi_rdata <= 32'h00000000;
        `SPT_OFS_RXDATA: s_axi_rdata <= rxdata_q;
        `SPT_OFS_CMPRES: s_axi_rdata <= cmpres_q;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SPT_RESP_ERR;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: tb/spt_codec.sv
// Far-end codec model: bit clock, frame sync and capture of driven bits
`timescale 1ns/100ps
`default_nettype none
module spt_codec (
  output var logic tx_bclk,
  output var logic tx_fsync,
  input wire logic tx_dout,
  input wire logic tx_dout_oe
);
  logic [63:0] got;
  int ngot;
  initial begin
    tx_bclk = 1'b0;
    tx_fsync = 1'b0;
  end
  // Clock runs only for the asked edges; sync set a quarter bit before each rise
  task automatic run(input int edges, input int resync);
    got = '0;
    ngot = 0;
    #13;
    for (int i = 0; i < edges; i++) begin
      tx_fsync = (i == 0 || i == resync);
      #100;
      tx_bclk = 1'b1;
      #200;
      tx_bclk = 1'b0;
      #100;
      // Released pin carries nothing, so only driven bits are kept
      if (tx_dout_oe === 1'b1) begin
        got = {got[62:0], tx_dout};
        ngot++;
      end
    end
    tx_fsync = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/spt_tx_sva.sv
// Port checker for the serial transmit framer
`timescale 1ns/100ps
`default_nettype none
`include "spt_consts.vh"
module spt_tx_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_bclk,
  input wire logic tx_dout,
  input wire logic tx_dout_oe
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Cycles since the bit clock pin rose; saturates so a stopped link reads 15
  logic bclk_q;
  logic [3:0] since_q;
  always_ff @(posedge clk) begin
    bclk_q <= tx_bclk;
    if (rst) begin
      since_q <= 4'hF;
    end else if (tx_bclk && !bclk_q) begin
      since_q <= 4'h0;
    end else if (since_q != 4'hF) begin
      since_q <= since_q + 4'h1;
    end
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (s_wr_take |-> ##2 (s_axi_bvalid && !s_axi_awready))
    else $error("write response late");
  AST_WR_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_WR_FREE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_wready)
    else $error("write channel not freed");
  AST_WR_UNMAPPED: assert property (s_wr_take ##0 (s_axi_awaddr > `SPT_OFS_CMPRES)
    |-> ##2 (s_axi_bresp == `SPT_RESP_ERR)) else $error("unmapped write accepted");
  AST_RD_ANSWER: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  AST_RD_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  AST_RD_UNMAPPED: assert property (s_rd_take ##0 (s_axi_araddr > `SPT_OFS_CMPRES)
    |=> s_axi_rresp == `SPT_RESP_ERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  // A released pin may settle at any time; a driven level and any enable change must follow a bit clock edge
  AST_LINK_EDGE: assert property (($changed(tx_dout) && tx_dout_oe) || $changed(tx_dout_oe) |-> since_q <= 4'h5)
    else $error("serial output moved away from a bit clock edge");
  AST_LINK_IDLE: assert property (since_q == 4'hF |-> !tx_dout_oe)
    else $error("data pin driven with link clock stopped");
endmodule
bind spt_tx spt_tx_sva spt_tx_sva_inst (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_bclk(tx_bclk),
  .tx_dout(tx_dout), .tx_dout_oe(tx_dout_oe));
`default_nettype wire

// File: tb/spt_tx_test.sv
// Self-checking bench for the serial transmit framer
`timescale 1ns/100ps
`default_nettype none
`include "spt_consts.vh"
module spt_tx_test;
  logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rdat;
  logic [63:0] got, ngot;
  logic [1:0] rs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire tx_bclk, tx_fsync, tx_dout, tx_dout_oe;
  int miscompares = 0;
  int checked = 0;
  localparam logic [31:0] DAT = 32'hC3A596E1;
  spt_tx spt_tx_inst (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tx_bclk(tx_bclk), .tx_fsync(tx_fsync), .tx_dout(tx_dout),
    .tx_dout_oe(tx_dout_oe));
  spt_codec spt_codec_inst (.tx_bclk(tx_bclk), .tx_fsync(tx_fsync), .tx_dout(tx_dout),
    .tx_dout_oe(tx_dout_oe));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Address and data offered together; bready raised late to exercise the stall
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    // No cycle limit here; a hang is left to the watchdog
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 1'b1;
    @(posedge clk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    rdat = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Transmitter held off while set up, so nothing starts on half a setting
  task automatic cfg(input logic [31:0] p1, t1, t2, mc, ch, d);
    bus_wr(`SPT_OFS_PCTL2, 32'h0);
    bus_wr(`SPT_OFS_PCTL1, p1);
    bus_wr(`SPT_OFS_TCTL1, t1);
    bus_wr(`SPT_OFS_TCTL2, t2);
    bus_wr(`SPT_OFS_MCTL2, mc);
    bus_wr(`SPT_OFS_CHEN, ch);
    bus_wr(`SPT_OFS_TXDATA, d);
    bus_wr(`SPT_OFS_PCTL2, 32'h1);
  endtask
  task automatic frame(input int edges, input int resync);
    spt_codec_inst.run(edges, resync);
    got = spt_codec_inst.got;
    ngot = 64'(spt_codec_inst.ngot);
    @(posedge clk);
  endtask
  task automatic t_bus;
    bus_rd(`SPT_OFS_TCTL2);
    chk("tctl2 reset", {rdat, 30'h0, rs}, {`SPT_RST_WORD, 32'h0});
    bus_rd(8'h40);
    chk("unmapped read", {rdat, 30'h0, rs}, {32'h0, 30'h0, `SPT_RESP_ERR});
    bus_wr(8'h44, 32'hFFFFFFFF);
    chk("unmapped write", {62'h0, rs}, {62'h0, `SPT_RESP_ERR});
  endtask
  task automatic t_word_len;
    int lens[7] = '{8, 12, 16, 20, 24, 32, 8};
    logic [63:0] m;
    for (int c = 0; c < 7; c++) begin
      cfg(32'h0, 32'(c) << 5, 32'h0, 32'h0, 32'h0, DAT);
      frame(lens[c] + 1, -1);
      m = (64'h1 << lens[c]) - 64'h1;
      chk("word bits", ngot, 64'(lens[c]));
      chk("word data", got & m, {32'h0, DAT} & m);
    end
  endtask
  task automatic t_dual;
    cfg(32'h0, 32'h0100, 32'h8040, 32'h0, 32'h0, DAT);
    frame(33, -1);
    chk("dual bits", ngot, 64'h20);
    chk("dual data", got, {32'h0, DAT[7:0], DAT[7:0], DAT[15:0]});
  endtask
  task automatic t_compand;
    logic [31:0] laws[4] = '{32'h10, 32'h10, 32'h18, 32'h18};
    logic [31:0] vals[4] = '{32'h7FFC, 32'h8000, 32'h7FF8, 32'h8000};
    logic [7:0] codes[4] = '{8'h80, 8'h00, 8'hAA, 8'h2A};
    cfg(32'h0, 32'h40, 32'h08, 32'h0, 32'h0, DAT);
    frame(9, -1);
    chk("lsb first", got, 64'h87);
    cfg(32'h0, 32'hA0, 32'h18, 32'h0, 32'h0, 32'h7FF8);
    frame(9, -1);
    chk("alaw serial", {ngot[31:0], got[31:0]}, {32'h8, 32'hAA});
    bus_wr(`SPT_OFS_PCTL2, 32'h0);
    for (int k = 0; k < 4; k++) begin
      bus_wr(`SPT_OFS_PCTL1, laws[k]); // Idle compressor follows the receive law field
      bus_wr(`SPT_OFS_TXDATA, vals[k]);
      bus_rd(`SPT_OFS_CMPRES);
      chk("compress", {56'h0, rdat[7:0]}, {56'h0, codes[k]});
    end
    // Receive law is still A-law here: full-scale positive code expands to 0x7E00
    bus_wr(`SPT_OFS_RXBUF, 32'hAA);
    bus_rd(`SPT_OFS_RXDATA);
    chk("expand", {32'h0, rdat}, 64'h7E00);
  endtask
  task automatic t_sync;
    cfg(32'h0, 32'h0, 32'h4, 32'h0, 32'h0, DAT);
    frame(9, 3);
    chk("ignored sync", {ngot[31:0], got[31:0]}, {32'h8, 24'h0, DAT[7:0]});
    bus_rd(`SPT_OFS_PCTL2);
    chk("no sync error", {63'h0, rdat[1]}, 64'h0);
    cfg(32'h0, 32'h0, 32'h0, 32'h0, 32'h0, DAT);
    frame(12, 3);
    chk("abort", {ngot[31:0], got[31:0]}, {32'hB, 21'h0, DAT[7:5], DAT[7:0]});
    bus_rd(`SPT_OFS_PCTL2);
    chk("sync error set", {63'h0, rdat[1]}, 64'h1);
    bus_wr(`SPT_OFS_PCTL2, 32'h3);
    bus_rd(`SPT_OFS_PCTL2);
    chk("sync error clear", {63'h0, rdat[1]}, 64'h0);
  endtask
  task automatic t_chan;
    int want[4] = '{32, 16, 16, 16};
    for (int m = 0; m < 4; m++) begin
      cfg(32'h0, 32'h0300, 32'h0, 32'(m), 32'h5, 32'h5A);
      frame(33, -1);
      chk("chan bits", ngot, 64'(want[m]));
      chk("chan data", {48'h0, got[15:0]}, 64'h5A5A);
    end
    cfg(32'h40, 32'h0, 32'h0, 32'h1, 32'hF0, DAT);
    frame(9, -1);
    chk("bit level on", ngot, 64'h4);
    cfg(32'h0, 32'h0, 32'h0, 32'h1, 32'hF0, DAT);
    frame(9, -1);
    chk("bit level off", ngot, 64'h0);
  endtask
  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Whole run needs about 0.2 ms; a hang past 2 ms counts as a failure
  initial begin
    #2000000;
    miscompares++;
    results;
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_bus;
    t_word_len;
    t_dual;
    t_compand;
    t_sync;
    t_chan;
    results;
  end
endmodule
`default_nettype wire
